// >>> adcc_pkg.sv
`default_nettype none
package adcc_pkg;
  // Bus clock and the converter's internal clock derived from it
  localparam int CLK_PERIOD_NS = 4;
  localparam int ADC_CLK_PERIOD_NS = 16;
  localparam int ADC_DIV = (ADC_CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] CONV_TICKS = 5'h10;

  localparam int ADDR_W = 8;
  localparam int AIN_W = 10;
  localparam int NUM_CH = 4;
  localparam int NUM_PINS = 6;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  // Pin number of port A used by each converter channel
  localparam int CH_PIN [NUM_CH] = '{0, 1, 4, 5};

  localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 8'h3C;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_PORT_DATA = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_PORT_DIR = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_PORT_PIN = 8'h4C;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h50;

  localparam int SCR_FLAG_BIT = 7;
  localparam int SCR_IEN_BIT = 6;
  localparam int SCR_CONT_BIT = 5;
  localparam int SCR_CH_W = 5;
  localparam int PEND_BIT = 7;

  localparam logic [SCR_CH_W-1:0] CH_RST = 5'h1F;
  localparam logic [NUM_PINS-1:0] PORT_RST = 6'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_HOLD} adcc_state_t;
endpackage
`default_nettype wire

// >>> adcc_top.sv
// Operation
// - The selected channel's shared pin is forced to be a converter input; other pins stay port pins.
// - Port data or direction writes do not change the behaviour of the selected pin.
// - A port read of the selected pin gives 0 if its direction bit is 0, else the data latch.
// - Input at supply codes FF, at ground 00, linear between, clamped beyond the rails.
// - Each conversion takes exactly sixteen converter clocks from start to result.
// - A conversion starts on the first converter clock edge after any status/control write with byte lane 0 strobed, once no full buffer stalls the converter.
// - In continuous mode each new result overwrites the result register, read or not.
// - Continuous conversions run until software clears the continuous bit.
// - The complete flag sets at the end of each conversion and clears on the next result read.
// - Conversion is monotonic with no missing codes.
// - Flag set with interrupt enable raises the interrupt request and its pending bit.
//
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none

module adcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_out = cnt_q != (PW+1)'(DEPTH);
  assign out_valid_out = cnt_q != '0;
  assign out_data_out = mem_q[rp_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule

module adcc_top import adcc_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [NUM_CH-1:0][AIN_W-1:0] analog_level_in,
  input wire logic [NUM_PINS-1:0] port_pin_in,
  output logic [NUM_PINS-1:0] port_pin_out,
  output logic [NUM_PINS-1:0] port_pin_oe_out,
  output logic irq_out
);
  localparam int DIV_W = $clog2(ADC_DIV);
  localparam int A_DIV = ADC_DIV;
  localparam int A_CONV_CYC = ADC_DIV * 16;

  adcc_state_t st_q;
  logic [DIV_W-1:0] div_q;
  logic [4:0] cnt_q;
  logic tick;
  logic start_pend_q;
  logic start_fire;
  logic conv_done;
  logic [7:0] sample_q;
  logic push_valid_q;
  logic push_ready;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic drain_ready;
  logic pop;
  logic [7:0] result_q;
  logic flag_q;
  logic ien_q;
  logic cont_q;
  logic [SCR_CH_W-1:0] ch_q;
  logic [NUM_PINS-1:0] pdata_q;
  logic [NUM_PINS-1:0] pdir_q;
  logic [NUM_PINS-1:0] pin_s1_q;
  logic [NUM_PINS-1:0] pin_s2_q;
  logic [NUM_CH-1:0][AIN_W-1:0] ain_s1_q;
  logic [NUM_CH-1:0][AIN_W-1:0] ain_s2_q;
  logic ch_valid;
  logic [AIN_W-1:0] ain_sel;
  logic [NUM_PINS-1:0] sel_mask;
  logic [NUM_PINS-1:0] pin_read;
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic wr_fire;
  logic scr_wr;
  logic ar_fire;
  logic rd_result;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;

  function automatic logic [7:0] clamp_code(input logic [AIN_W-1:0] v);
    logic signed [AIN_W-1:0] s;
    s = $signed(v);
    if (s < 0) return CODE_MIN;
    if (s > 255) return CODE_MAX;
    return v[7:0];
  endfunction

  // Pins and analog levels come from outside the clock domain
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      ain_s1_q <= '0;
      ain_s2_q <= '0;
    end else begin
      pin_s1_q <= port_pin_in;
      pin_s2_q <= pin_s1_q;
      ain_s1_q <= analog_level_in;
      ain_s2_q <= ain_s1_q;
    end
  end

  assign ch_valid = ch_q < SCR_CH_W'(NUM_CH);
  assign ain_sel = ch_valid ? ain_s2_q[ch_q[1:0]] : '0;

  always_comb begin
    sel_mask = '0;
    if (ch_valid) sel_mask[CH_PIN[ch_q[1:0]]] = 1'b1;
  end

  // Selected pin never driven, so port writes cannot reach it
  assign port_pin_oe_out = pdir_q & ~sel_mask;
  assign port_pin_out = pdata_q;
  assign pin_read = (sel_mask & pdir_q & pdata_q)
                  | (~sel_mask & ((pdir_q & pdata_q) | (~pdir_q & pin_s2_q)));

  // Converter clock: one tick every ADC_DIV bus cycles
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) div_q <= '0;
    else if (tick) div_q <= '0;
    else div_q <= div_q + 1'b1;
  end
  assign tick = div_q == DIV_W'(ADC_DIV - 1);

  assign start_fire = tick && (st_q != ST_HOLD)
                   && (start_pend_q || (st_q == ST_IDLE && cont_q));
  assign conv_done = tick && st_q == ST_CONV && !start_pend_q
                   && cnt_q == CONV_TICKS - 5'h01;

  // Set wins over the clear when a write meets the start tick
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) start_pend_q <= 1'b0;
    else if (scr_wr) start_pend_q <= 1'b1;
    else if (start_fire) start_pend_q <= 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      sample_q <= CODE_MIN;
      push_valid_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_CONV: begin
          if (start_fire) begin
            st_q <= ST_CONV;
            cnt_q <= '0;
            sample_q <= clamp_code(ain_sel);
          end else if (conv_done) begin
            st_q <= ST_HOLD;
            push_valid_q <= 1'b1;
          end else if (tick && st_q == ST_CONV) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_HOLD: begin
          // Full buffer stalls the converter instead of losing a result
          if (push_ready) begin
            push_valid_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  adcc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .in_data_in(sample_q),
    .in_valid_in(push_valid_q),
    .in_ready_out(push_ready),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(drain_ready)
  );

  // Result held steady while a read answer waits on the bus
  assign drain_ready = !s_axi_rvalid_out;
  assign pop = fifo_valid && drain_ready;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) result_q <= RESULT_RST;
    else if (pop) result_q <= fifo_data;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) flag_q <= 1'b0;
    else if (pop) flag_q <= 1'b1;
    else if (rd_result) flag_q <= 1'b0;
  end

  assign irq_out = flag_q & ien_q;

  // Register write path: address and data taken in either order
  assign s_axi_awready_out = !aw_have_q;
  assign s_axi_wready_out = !w_have_q;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_out;
  assign wa = {aw_addr_q[ADDR_W-1:2], 2'b00};
  assign scr_wr = wr_fire && w_lane_q && wa == OFF_STATUS_CONTROL;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= '0;
      w_lane_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid_in && !w_have_q) begin
        w_have_q <= 1'b1;
        w_byte_q <= s_axi_wdata_in[7:0];
        w_lane_q <= s_axi_wstrb_in[0];
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (wa == OFF_STATUS_CONTROL || wa == OFF_PORT_DATA || wa == OFF_PORT_DIR
                          || wa == OFF_RESULT || wa == OFF_PORT_PIN || wa == OFF_INT_STATUS)
                         ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ien_q <= 1'b0;
      cont_q <= 1'b0;
      ch_q <= CH_RST;
      pdata_q <= PORT_RST;
      pdir_q <= PORT_RST;
    end else if (wr_fire && w_lane_q) begin
      if (wa == OFF_STATUS_CONTROL) begin
        ien_q <= w_byte_q[SCR_IEN_BIT];
        cont_q <= w_byte_q[SCR_CONT_BIT];
        ch_q <= w_byte_q[SCR_CH_W-1:0];
      end
      if (wa == OFF_PORT_DATA) pdata_q <= w_byte_q[NUM_PINS-1:0];
      if (wa == OFF_PORT_DIR) pdir_q <= w_byte_q[NUM_PINS-1:0];
    end
  end

  // Register read path
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign ra = {s_axi_araddr_in[ADDR_W-1:2], 2'b00};
  assign rd_result = ar_fire && ra == OFF_RESULT;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= RESP_OKAY;
      s_axi_rdata_out <= '0;
      unique case (ra)
        OFF_STATUS_CONTROL: s_axi_rdata_out[7:0] <= {flag_q, ien_q, cont_q, ch_q};
        OFF_RESULT: s_axi_rdata_out[7:0] <= result_q;
        OFF_PORT_DATA: s_axi_rdata_out[NUM_PINS-1:0] <= pdata_q;
        OFF_PORT_DIR: s_axi_rdata_out[NUM_PINS-1:0] <= pdir_q;
        OFF_PORT_PIN: s_axi_rdata_out[NUM_PINS-1:0] <= pin_read;
        OFF_INT_STATUS: s_axi_rdata_out[PEND_BIT] <= flag_q & ien_q;
        default: s_axi_rresp_out <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // Cycles since the last start, for checking conversion length
  logic [7:0] cyc_q;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) cyc_q <= '0;
    else if (start_fire) cyc_q <= '0;
    else if (cyc_q != 8'hFF) cyc_q <= cyc_q + 8'h01;
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  property p_sel_pin_input;
    (sel_mask & port_pin_oe_out) == '0;
  endproperty
  a_sel_pin_input: assert property (p_sel_pin_input) else $error("selected pin is driven");

  property p_dir_write_no_effect;
    scr_wr == 1'b0 && wr_fire && wa == OFF_PORT_DIR && ch_valid
      |=> (port_pin_oe_out & sel_mask) == '0 && $stable(ch_q);
  endproperty
  a_dir_write_no_effect: assert property (p_dir_write_no_effect) else $error("dir write moved pin");

  property p_pin_read;
    ar_fire && ra == OFF_PORT_PIN
      |=> (s_axi_rdata_out[NUM_PINS-1:0] & $past(sel_mask)) == ($past(sel_mask) & $past(pdir_q) & $past(pdata_q));
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("wrong read of converter pin");

  property p_clamp_low;
    start_fire && $signed(ain_sel) < 0 |=> sample_q == CODE_MIN;
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("below-rail input not coded 00");

  property p_conv_len;
    conv_done |-> cyc_q == 8'(A_CONV_CYC - 1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_start_after_write;
    scr_wr && st_q != ST_HOLD |-> ##[1:A_DIV] start_fire;
  endproperty
  a_start_after_write: assert property (p_start_after_write) else $error("no start after write");

  property p_result_load;
    pop |=> flag_q && result_q == $past(fifo_data);
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded");

  property p_cont_restart;
    st_q == ST_HOLD && push_ready && cont_q |=> ##[0:A_DIV] start_fire;
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("continuous mode stalled");

  property p_flag_clear;
    $fell(flag_q) |-> $past(rd_result);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without read");

  property p_irq;
    flag_q && ien_q |-> irq_out ##1 (irq_out || !flag_q || !ien_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");

  property p_oneshot_stop;
    st_q == ST_IDLE && !cont_q && !start_pend_q |-> !start_fire;
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("unrequested conversion");

  c_fifo_full: cover property (!push_ready && fifo_valid);
  c_cont_twice: cover property (cont_q && pop ##[1:200] pop);
  c_flag_read: cover property (flag_q && rd_result ##1 !flag_q);
endmodule
`default_nettype wire

// >>> adcc_analog_model.sv
`default_nettype none
module adcc_analog_model import adcc_pkg::*; (
  input wire logic [NUM_CH-1:0][AIN_W-1:0] src_level_in,
  input wire logic [NUM_PINS-1:0] ext_pin_in,
  input wire logic [NUM_PINS-1:0] pin_drive_in,
  input wire logic [NUM_PINS-1:0] pin_oe_in,
  output logic [NUM_CH-1:0][AIN_W-1:0] analog_level_out,
  output logic [NUM_PINS-1:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Wire level: the device wins where it drives, the outside source elsewhere
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_level_out[p] = pin_oe_in[p] ? pin_drive_in[p] : ext_pin_in[p];
    end
  end

  // A channel pin that the device drives is pulled to a rail, so a failed
  // takeover shows up as a wrong code instead of passing silently
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (pin_oe_in[CH_PIN[c]]) begin
        analog_level_out[c] = pin_drive_in[CH_PIN[c]] ? 10'h0FF : 10'h000;
      end else begin
        analog_level_out[c] = src_level_in[c];
      end
    end
  end
endmodule
`default_nettype wire

// >>> adc_conversion_control_tb.sv
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module adc_conversion_control_tb import adcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [9:0] LV [7] = '{10'h3FB, 10'h000, 10'h001, 10'h07F, 10'h080, 10'h0FF, 10'h12C};
  localparam logic [7:0] CD [7] = '{8'h00, 8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF, 8'hFF};

  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NUM_CH-1:0][AIN_W-1:0] src_level = '0;
  logic [NUM_CH-1:0][AIN_W-1:0] level;
  logic [NUM_PINS-1:0] ext_pin = 6'h30;
  logic [NUM_PINS-1:0] pin_lvl, pin_out, pin_oe;
  int errors = 0;
  int n_compared = 0;

  always #2 clk_sys_in = ~clk_sys_in;

  adcc_top uut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .analog_level_in(level), .port_pin_in(pin_lvl), .port_pin_out(pin_out),
    .port_pin_oe_out(pin_oe), .irq_out(irq)
  );

  adcc_analog_model model (
    .src_level_in(src_level), .ext_pin_in(ext_pin), .pin_drive_in(pin_out),
    .pin_oe_in(pin_oe), .analog_level_out(level), .pin_level_out(pin_lvl)
  );

  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic hang_abort();
    errors++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask

  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
      aw = aw | awready;
      w = w | wready;
      awvalid <= !aw;
      wvalid <= !w;
    end while (!(aw && w) && n < 200);
    while (!bvalid && n < 200) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 200) hang_abort();
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (!arready && n < 200);
    arvalid <= 1'b0;
    while (!rvalid && n < 200) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 200) hang_abort();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic check_rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    `CHK(r, RESP_OKAY)
    `CHK(d, e)
  endtask

  task automatic wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 300) begin
      @(posedge clk_sys_in);
      c++;
    end
    if (c >= 300) hang_abort();
  endtask

  task automatic sc_reset();
    logic [31:0] d;
    logic [1:0] r;
    `CHK(pin_oe, 6'h00)
    `CHK(irq, 1'b0)
    check_rd(OFF_STATUS_CONTROL, 32'h0000_001F);
    axi_read(8'h60, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h0000_0000)
    axi_write(8'h60, 8'h55, RESP_SLVERR);
    axi_write(OFF_RESULT, 8'h55, RESP_OKAY);
    check_rd(OFF_RESULT, 32'h0000_0000);
  endtask

  // Start timing is counted from the edge at which the write answer is taken
  task automatic convert_one(input logic [1:0] ch, input logic [9:0] lv, input logic [7:0] cd, input bit restart);
    int c;
    logic [7:0] scr;
    scr = 8'h40 | {6'h00, ch};
    src_level[ch] <= lv;
    axi_write(OFF_STATUS_CONTROL, scr, RESP_OKAY);
    if (restart) begin
      repeat (20) @(posedge clk_sys_in);
      // The interrupted conversion is never read back, its data is dropped
      axi_write(OFF_STATUS_CONTROL, scr, RESP_OKAY);
    end
    wait_irq(c);
    `CHK(c >= 66 && c <= 70, 1'b1)
    check_rd(OFF_INT_STATUS, 32'h0000_0080);
    check_rd(OFF_STATUS_CONTROL, {24'h00_0000, scr | 8'h80});
    check_rd(OFF_RESULT, {24'h00_0000, cd});
    check_rd(OFF_STATUS_CONTROL, {24'h00_0000, scr});
    `CHK(irq, 1'b0)
  endtask

  task automatic sc_encoding();
    for (int i = 0; i < 7; i++) begin
      convert_one(2'(i), LV[i], CD[i], i == 6);
    end
    repeat (300) @(posedge clk_sys_in);
    `CHK(irq, 1'b0)
    check_rd(OFF_STATUS_CONTROL, 32'h0000_0042);
  endtask

  task automatic sc_continuous();
    int c;
    logic [31:0] d;
    logic [1:0] r;
    bit seen;
    seen = 1'b0;
    src_level[0] <= 10'h010;
    axi_write(OFF_STATUS_CONTROL, 8'h60, RESP_OKAY);
    wait_irq(c);
    check_rd(OFF_RESULT, 32'h0000_0010);
    src_level[0] <= 10'h020;
    for (int i = 0; i < 10; i++) begin
      repeat (80) @(posedge clk_sys_in);
      axi_read(OFF_RESULT, d, r);
      seen = seen | (d === 32'h0000_0020);
    end
    `CHK(seen, 1'b1)
    axi_write(OFF_STATUS_CONTROL, 8'h40, RESP_OKAY);
    // Buffered results are drained before idling is judged
    repeat (8) begin
      repeat (100) @(posedge clk_sys_in);
      axi_read(OFF_RESULT, d, r);
    end
    repeat (300) @(posedge clk_sys_in);
    `CHK(irq, 1'b0)
    check_rd(OFF_STATUS_CONTROL, 32'h0000_0040);
  endtask

  task automatic sc_port();
    axi_write(OFF_PORT_DIR, 8'h3F, RESP_OKAY);
    axi_write(OFF_PORT_DATA, 8'h15, RESP_OKAY);
    axi_write(OFF_STATUS_CONTROL, 8'h02, RESP_OKAY);
    `CHK(pin_oe, 6'h2F)
    `CHK(pin_out, 6'h15)
    check_rd(OFF_PORT_PIN, 32'h0000_0015);
    axi_write(OFF_PORT_DATA, 8'h3F, RESP_OKAY);
    `CHK(pin_oe, 6'h2F)
    check_rd(OFF_PORT_PIN, 32'h0000_003F);
    axi_write(OFF_PORT_DIR, 8'h0F, RESP_OKAY);
    `CHK(pin_oe, 6'h0F)
    check_rd(OFF_PORT_PIN, 32'h0000_002F);
    axi_write(OFF_STATUS_CONTROL, 8'h1F, RESP_OKAY);
    check_rd(OFF_PORT_PIN, 32'h0000_003F);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    sc_reset();
    sc_encoding();
    sc_continuous();
    sc_port();
    print_verdict();
  end
endmodule
`default_nettype wire
